// ===== include/gauge_params.svh
`ifndef GAUGE_PARAMS_SVH
`define GAUGE_PARAMS_SVH

// Register offsets
`define OFS_PRIMARY_STATUS_FLAGS   7'h01
`define OFS_TEMPERATURE_AND_GAUGE  7'h02
`define OFS_CHARGE_COUNT_HIGH      7'h03
`define OFS_PACK_IDENTIFIER        7'h04
`define OFS_MEASURED_FULL_CAPACITY 7'h05
`define OFS_CHARGE_COUNT_LOW       7'h17
`define OFS_SOFT_RESET             7'h39

// Command byte fields
`define CMD_WRITE_BIT 7
`define SOFT_RESET_VALUE 8'h80

// Primary status flag bit positions
`define FLAG_CHARGING_BIT  7
`define FLAG_REPLACED_BIT  6
`define FLAG_OVERVOLT_BIT  5
`define FLAG_VALID_DIS_BIT 3
`define FLAG_EMPTY_BIT     1

// Reset values
`define RST_BYTE     8'h00
`define RST_REPLACED 1'b1

// Counting limits
`define SELF_DIS_LIMIT  13'h1000
`define VALID_CHG_COUNT 9'h100

// Temperature code bands
`define CODE_ZERO_C 4'h4
`define CODE_ABOVE_40C 4'h8
`define CODE_BELOW_M10C 4'h2

// Efficiency weights in quarter counts
`define WEIGHT_FULL   18'h00004
`define WEIGHT_WARM_CHG 18'h00004
`define WEIGHT_MILD_CHG 18'h00003
`define WEIGHT_COLD_CHG 18'h00002
`define WEIGHT_SD_HOT  18'h00008
`define WEIGHT_SD_NORM 18'h00004
`define WEIGHT_SD_COLD 18'h00002

// Capacity correction temperatures in degrees C
`define COOL_LIMIT_DEG 8'sh00
`define COLD_LIMIT_DEG -8'sh14
`define HYST_DEG       8'sh04

// Display blink: 4 Hz, so half period of 125 ms
`define CLK_KHZ       125000
`define BLINK_HALF_MS 125
`define BLINK_HALF_CYCLES (`CLK_KHZ * `BLINK_HALF_MS)

`endif

// ===== include/gauge_pkg.sv
package gauge_pkg;

	typedef enum logic [1:0] {
		BAND_WARM,
		BAND_COOL,
		BAND_COLD
	} band_t;

	typedef struct packed {
		band_t band;
	} calc_state_t;

	typedef struct packed {
		logic        init;
		logic        chg;
		logic        battery_replaced_flag;
		logic        cell_overvoltage_flag;
		logic        valid_discharge_flag;
		logic        empty_warning_flag;
		logic [17:0] available_charge_count;
		logic [7:0]  measured_full_capacity;
		logic [8:0]  chg_run;
		logic [12:0] sd_cnt;
		logic [17:0] dis_run;
		logic [23:0] blink_div;
		logic        blink;
		logic        rsp_valid;
		logic [7:0]  rsp_data;
		logic        first_display_segment;
		logic [3:0]  gauge;
	} state_t;

endpackage

// ===== include/gauge_if.sv
`timescale 1ns/1ps
`default_nettype none

interface gauge_if;
	logic [7:0]        count_high;
	logic [7:0]        full_ref;
	logic signed [7:0] temp_deg;
	logic [3:0]        sixteenths;

	modport calc (
		input  count_high,
		input  full_ref,
		input  temp_deg,
		output sixteenths
	);
	modport user (
		output count_high,
		output full_ref,
		output temp_deg,
		input  sixteenths
	);
endinterface

`default_nettype wire

// ===== core/gauge_calc.sv
`timescale 1ns/1ps
`default_nettype none
`include "gauge_params.svh"

module gauge_calc (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	gauge_if.calc    gif
);
	gauge_pkg::calc_state_t st;
	gauge_pkg::calc_state_t next_st;
	logic [11:0] num;
	logic [11:0] scaled;
	logic [11:0] quot;

	always_comb begin
		next_st = st;
		if (gif.temp_deg < `COLD_LIMIT_DEG) begin
			next_st.band = gauge_pkg::BAND_COLD;
		end else if (st.band == gauge_pkg::BAND_WARM) begin
			if (gif.temp_deg < `COOL_LIMIT_DEG) begin
				next_st.band = gauge_pkg::BAND_COOL;
			end
		end else if (gif.temp_deg > `HYST_DEG) begin
			next_st.band = gauge_pkg::BAND_WARM;
		end else begin
			next_st.band = gauge_pkg::BAND_COOL;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st <= '{band: gauge_pkg::BAND_WARM};
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		num = {gif.count_high, 4'h0};
		case (st.band)
			gauge_pkg::BAND_WARM: scaled = num;
			gauge_pkg::BAND_COOL: scaled = 12'((num * 3) >> 2);
			gauge_pkg::BAND_COLD: scaled = num >> 1;
			default: scaled = num;
		endcase
		// An empty reference would divide by zero, so report full
		quot = (gif.full_ref == 8'h00) ? 12'hFFF : scaled / {4'h0, gif.full_ref};
		gif.sixteenths = (quot > 12'h00F) ? 4'hF : quot[3:0];
	end
endmodule

`default_nettype wire

// ===== core/charge_gauge_status_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "gauge_params.svh"

// Contract
// - Charging flag follows sense below -400uV
// - Replaced flag set on corruption or reset
// - Replaced flag clears at full or empty
// - Overvoltage flag mirrors cell above 2.0V
// - Valid discharge set leaving full count
// - Valid discharge cleared by four causes
// - Empty flag latched until valid charge
// - Overload suppresses empty detection
// - Segment one blinks 4Hz while empty
// - Temperature code in upper nibble
// - Temperature chooses efficiency and self-discharge
// - Gauge in sixteenths from count, reference
// - Cold bands scale gauge 0.75, 0.5
// - 4C hysteresis at the zero boundary
// - Count up on charge, down otherwise
// - Strap selects count preload at reset
// - Low byte halts when high is zero
// - Valid charge clears low byte
// - Host writes high byte of count
// - Pack identifier host storage, no default
// - Full capacity learned, preset, host RW
// - Command bit 7 writes, invalid ignored
// - Bytes travel least significant bit first
module charge_gauge_status_registers #(
	parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	// Command byte link
	input  wire logic        CMD_VALID_I,
	input  wire logic [7:0]  CMD_BYTE_I,
	input  wire logic [7:0]  CMD_DATA_I,
	output var  logic        RSP_VALID_O,
	output var  logic [7:0]  RSP_DATA_O,
	// Measurement events and levels
	input  wire logic        CHARGE_COUNT_I,
	input  wire logic        DISCHARGE_COUNT_I,
	input  wire logic        SELF_DISCHARGE_COUNT_I,
	input  wire logic        SENSE_CHARGE_I,
	input  wire logic        CELL_PRESENT_I,
	input  wire logic        REG_CORRUPT_I,
	input  wire logic        CELL_OVERVOLT_I,
	input  wire logic        CELL_EMPTY_I,
	input  wire logic        DISCHARGE_OVERLOAD_I,
	input  wire logic [3:0]  TEMPERATURE_CODE_I,
	input  wire logic signed [7:0] TEMPERATURE_DEG_I,
	input  wire logic [7:0]  PROGRAMMED_FULL_CAPACITY_I,
	input  wire logic        FOURTH_PROGRAM_INPUT_I,
	// Display
	output var  logic        FIRST_DISPLAY_SEGMENT_O,
	output var  logic [3:0]  GAUGE_LEVEL_O
);
	gauge_pkg::state_t st;
	gauge_pkg::state_t next_st;
	logic [7:0] pack_identifier;
	logic       id_write;
	logic       cmd_write;
	logic [6:0] cmd_addr;
	logic       valid_charge;
	logic       empty_set;
	logic       lmd_update;
	logic [7:0] flags;
	logic [7:0] read_data;

	gauge_if gif ();

	gauge_calc u_calc (
		.CLK_I   (CLK_I),
		.RST_N_I (RST_N_I),
		.gif     (gif.calc)
	);

	function automatic logic [17:0] charge_weight(input logic [3:0] code);
		if (code >= `CODE_ZERO_C) begin
			charge_weight = `WEIGHT_WARM_CHG;
		end else if (code >= `CODE_BELOW_M10C) begin
			charge_weight = `WEIGHT_MILD_CHG;
		end else begin
			charge_weight = `WEIGHT_COLD_CHG;
		end
	endfunction

	function automatic logic [17:0] self_dis_weight(input logic [3:0] code);
		if (code >= `CODE_ABOVE_40C) begin
			self_dis_weight = `WEIGHT_SD_HOT;
		end else if (code >= `CODE_ZERO_C) begin
			self_dis_weight = `WEIGHT_SD_NORM;
		end else begin
			self_dis_weight = `WEIGHT_SD_COLD;
		end
	endfunction

	// Quarter-count fraction bits hold efficiency remainders below the low byte
	function automatic logic [17:0] count_down(input logic [17:0] available_charge_count, input logic [17:0] w);
		if (available_charge_count[17:10] == 8'h00) begin
			count_down = available_charge_count;
		end else if (available_charge_count < w) begin
			count_down = 18'h00000;
		end else begin
			count_down = available_charge_count - w;
		end
	endfunction

	assign cmd_write = CMD_BYTE_I[`CMD_WRITE_BIT];
	assign cmd_addr  = CMD_BYTE_I[6:0];
	// Bit 0 of each byte is the first bit on the wire
	assign id_write  = CMD_VALID_I && cmd_write && (cmd_addr == `OFS_PACK_IDENTIFIER);

	assign gif.count_high = st.available_charge_count[17:10];
	assign gif.full_ref   = (st.measured_full_capacity != 8'h00) ? st.measured_full_capacity : PROGRAMMED_FULL_CAPACITY_I;
	assign gif.temp_deg   = TEMPERATURE_DEG_I;

	always_comb begin
		flags = 8'h00;
		flags[`FLAG_CHARGING_BIT]  = st.chg;
		flags[`FLAG_REPLACED_BIT]  = st.battery_replaced_flag;
		flags[`FLAG_OVERVOLT_BIT]  = st.cell_overvoltage_flag;
		flags[`FLAG_VALID_DIS_BIT] = st.valid_discharge_flag;
		flags[`FLAG_EMPTY_BIT]     = st.empty_warning_flag;
		case (cmd_addr)
			`OFS_PRIMARY_STATUS_FLAGS:   read_data = flags;
			`OFS_TEMPERATURE_AND_GAUGE:  read_data = {TEMPERATURE_CODE_I, st.gauge};
			`OFS_CHARGE_COUNT_HIGH:      read_data = st.available_charge_count[17:10];
			`OFS_PACK_IDENTIFIER:        read_data = pack_identifier;
			`OFS_MEASURED_FULL_CAPACITY: read_data = st.measured_full_capacity;
			`OFS_CHARGE_COUNT_LOW:       read_data = st.available_charge_count[9:2];
			default:                     read_data = 8'h00;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.rsp_valid = 1'b0;

		// Charging is recognised on the sense level, but a DISCHARGE_COUNT_I event cancels it; self-discharge does not
		next_st.chg  = SENSE_CHARGE_I && !DISCHARGE_COUNT_I;
		valid_charge = next_st.chg && !st.chg;
		next_st.cell_overvoltage_flag  = CELL_OVERVOLT_I;
		empty_set    = CELL_EMPTY_I && !DISCHARGE_OVERLOAD_I && !st.empty_warning_flag;
		lmd_update   = 1'b0;

		// Count movement
		if (CHARGE_COUNT_I) begin
			next_st.available_charge_count = (st.available_charge_count > 18'h3FFFF - charge_weight(TEMPERATURE_CODE_I)) ? 18'h3FFFF
				: st.available_charge_count + charge_weight(TEMPERATURE_CODE_I);
			next_st.chg_run = (st.chg_run == `VALID_CHG_COUNT) ? st.chg_run : st.chg_run + 9'h001;
		end else if (DISCHARGE_COUNT_I) begin
			next_st.available_charge_count = count_down(st.available_charge_count, `WEIGHT_FULL);
			next_st.dis_run = st.dis_run + `WEIGHT_FULL;
		end else if (SELF_DISCHARGE_COUNT_I) begin
			next_st.available_charge_count = count_down(st.available_charge_count, self_dis_weight(TEMPERATURE_CODE_I));
			next_st.sd_cnt = (st.sd_cnt > `SELF_DIS_LIMIT) ? st.sd_cnt : st.sd_cnt + 13'h0001;
		end
		if (valid_charge) begin
			next_st.available_charge_count[9:0] = 10'h000;
			next_st.chg_run  = 9'h000;
		end

		// Empty warning stays until a valid charge; a new detection wins
		if (empty_set) begin
			next_st.empty_warning_flag = 1'b1;
		end else if (valid_charge) begin
			next_st.empty_warning_flag = 1'b0;
		end

		// Full capacity is learned from a qualified full-to-empty discharge
		if (empty_set && st.valid_discharge_flag && TEMPERATURE_CODE_I >= `CODE_ZERO_C) begin
			next_st.measured_full_capacity = st.dis_run[17:10];
			lmd_update  = 1'b1;
		end

		// Host commands; writes to unknown addresses and read-only targets are dropped, reads of unknown addresses return zero
		if (CMD_VALID_I && !cmd_write) begin
			next_st.rsp_valid = 1'b1;
			next_st.rsp_data  = read_data;
		end else if (CMD_VALID_I) begin
			case (cmd_addr)
				`OFS_CHARGE_COUNT_HIGH: next_st.available_charge_count[17:10] = CMD_DATA_I;
				`OFS_MEASURED_FULL_CAPACITY: begin
					next_st.measured_full_capacity = CMD_DATA_I;
					lmd_update  = 1'b1;
				end
				`OFS_SOFT_RESET: begin
					// Only the top bit alone is a defined reset request
					if (CMD_DATA_I == `SOFT_RESET_VALUE) begin
						next_st.init = 1'b1;
					end
				end
				default: next_st.init = next_st.init;
			endcase
		end

		// Valid discharge: clears first, then the start of a discharge at full wins
		if (lmd_update || st.sd_cnt > `SELF_DIS_LIMIT || st.chg_run == `VALID_CHG_COUNT
				|| (empty_set && TEMPERATURE_CODE_I < `CODE_ZERO_C)) begin
			next_st.valid_discharge_flag = 1'b0;
		end
		if (DISCHARGE_COUNT_I && !st.valid_discharge_flag && st.available_charge_count[17:10] == st.measured_full_capacity) begin
			next_st.valid_discharge_flag     = 1'b1;
			next_st.sd_cnt  = 13'h0000;
			next_st.dis_run = 18'h00000;
		end

		// Replaced flag: clear at full or empty, corruption detection wins
		if (st.chg && st.available_charge_count[17:10] == st.measured_full_capacity) begin
			next_st.battery_replaced_flag = 1'b0;
		end else if (empty_set) begin
			next_st.battery_replaced_flag = 1'b0;
		end
		if (CELL_PRESENT_I && REG_CORRUPT_I) begin
			next_st.battery_replaced_flag = 1'b1;
		end

		// Reset loading; the strap is sampled here, after reset release
		if (st.init) begin
			next_st.init = 1'b0;
			next_st.battery_replaced_flag  = 1'b1;
			next_st.valid_discharge_flag  = 1'b0;
			next_st.measured_full_capacity  = PROGRAMMED_FULL_CAPACITY_I;
			next_st.available_charge_count  = FOURTH_PROGRAM_INPUT_I ? 18'h00000
				: {PROGRAMMED_FULL_CAPACITY_I, 10'h000};
		end

		// Blink divider emits a toggle pulse every half period
		if (st.blink_div >= 24'(BLINK_HALF_CYCLES - 1)) begin
			next_st.blink_div = 24'h000000;
			next_st.blink     = !st.blink;
		end else begin
			next_st.blink_div = st.blink_div + 24'h000001;
		end
		next_st.first_display_segment  = st.empty_warning_flag && st.blink;
		next_st.gauge = gif.sixteenths;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st      <= '0;
			st.init <= 1'b1;
			st.battery_replaced_flag  <= `RST_REPLACED;
		end else begin
			st <= next_st;
		end
	end

	// Identifier keeps its content across resets and has no defined start value
	always_ff @(posedge CLK_I) begin
		if (id_write) begin
			pack_identifier <= CMD_DATA_I;
		end
	end

	assign RSP_VALID_O             = st.rsp_valid;
	assign RSP_DATA_O              = st.rsp_data;
	assign FIRST_DISPLAY_SEGMENT_O = st.first_display_segment;
	assign GAUGE_LEVEL_O           = st.gauge;
endmodule

`default_nettype wire

// ===== tb/gauge_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module gauge_host_model (
	// Clock
	input  wire logic       clk_i,
	// Answer from the device
	input  wire logic       rsp_valid_i,
	input  wire logic [7:0] rsp_data_i,
	// Command bytes, bit 0 first on the wire
	output var  logic       cmd_valid_o,
	output var  logic [7:0] cmd_byte_o,
	output var  logic [7:0] cmd_data_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_byte_o = 8'h00;
		cmd_data_o = 8'h00;
	end
	// Released lines show the inverse so a stale byte is never mistaken for live data
	task automatic send(input logic [7:0] cmd, input logic [7:0] dat);
		@(negedge clk_i);
		cmd_valid_o = 1'b1;
		cmd_byte_o = cmd;
		cmd_data_o = dat;
		@(negedge clk_i);
		cmd_valid_o = 1'b0;
		cmd_byte_o = ~cmd;
		cmd_data_o = ~dat;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		send({1'b1, a}, d);
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
		send({1'b0, a}, 8'h00);
		d = rsp_data_i;
		ok = rsp_valid_i;
	endtask
	// Capacity cleared first, then the top reset bit alone
	task automatic soft_reset();
		wr(7'h05, 8'h00);
		wr(7'h39, 8'h80);
	endtask
endmodule

`default_nettype wire

// ===== tb/charge_gauge_status_registers_sva.sv
`timescale 1ns/1ps
`default_nettype none

module charge_gauge_sva #(
	parameter int unsigned BLINK_HALF_CYCLES = 4
) (
	// Clock and reset
	input wire logic       CLK_I,
	input wire logic       RST_N_I,
	// Command link
	input wire logic       CMD_VALID_I,
	input wire logic [7:0] CMD_BYTE_I,
	input wire logic [7:0] CMD_DATA_I,
	input wire logic       RSP_VALID_O,
	input wire logic [7:0] RSP_DATA_O,
	// Measurement
	input wire logic       CHARGE_COUNT_I,
	input wire logic       DISCHARGE_COUNT_I,
	input wire logic       SELF_DISCHARGE_COUNT_I,
	input wire logic       SENSE_CHARGE_I,
	input wire logic       CELL_OVERVOLT_I,
	input wire logic [3:0] TEMPERATURE_CODE_I,
	// Display
	input wire logic       FIRST_DISPLAY_SEGMENT_O,
	input wire logic [3:0] GAUGE_LEVEL_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic        rd_flags;
	logic        rd_temp;
	logic        chg_cause;
	logic        quiet;
	logic [31:0] seg_run;
	assign rd_flags = CMD_VALID_I && CMD_BYTE_I == 8'h01;
	assign rd_temp = CMD_VALID_I && CMD_BYTE_I == 8'h02;
	assign chg_cause = SENSE_CHARGE_I && !DISCHARGE_COUNT_I;
	assign quiet = !CHARGE_COUNT_I && !DISCHARGE_COUNT_I && !SELF_DISCHARGE_COUNT_I;
	// A repetition cannot take the parameter, so the lit run is counted here
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			seg_run <= 32'h0;
		end else begin
			seg_run <= FIRST_DISPLAY_SEGMENT_O ? seg_run + 32'h1 : 32'h0;
		end
	end
	chk_read_answer: assert property (
		CMD_VALID_I && !CMD_BYTE_I[7] |=> RSP_VALID_O) else $error("read not answered");
	chk_write_silent: assert property (
		CMD_VALID_I && CMD_BYTE_I[7] |=> !RSP_VALID_O) else $error("write answered");
	chk_data_holds: assert property (
		!RSP_VALID_O |-> $stable(RSP_DATA_O)) else $error("read data moved");
	chk_charge_flag: assert property (
		rd_flags |=> RSP_DATA_O[7] == $past(chg_cause, 2)) else $error("charging flag wrong");
	chk_overvolt_flag: assert property (
		rd_flags && $stable(CELL_OVERVOLT_I) |=> RSP_DATA_O[5] == $past(CELL_OVERVOLT_I))
		else $error("overvoltage flag wrong");
	chk_temp_nibble: assert property (
		rd_temp && $stable(TEMPERATURE_CODE_I) |=> RSP_DATA_O[7:4] == $past(TEMPERATURE_CODE_I))
		else $error("temperature code wrong");
	chk_gauge_same: assert property (
		rd_temp |=> RSP_DATA_O[3:0] == $past(GAUGE_LEVEL_O)) else $error("gauge field differs");
	chk_unmapped_zero: assert property (
		CMD_VALID_I && CMD_BYTE_I == 8'h10 |=> RSP_DATA_O == 8'h00) else $error("unmapped not zero");
	chk_high_write: assert property (
		CMD_VALID_I && CMD_BYTE_I == 8'h83 && quiet ##1 quiet ##1 CMD_VALID_I && CMD_BYTE_I == 8'h03
		|=> RSP_DATA_O == $past(CMD_DATA_I, 3)) else $error("high byte write lost");
	chk_blink_run: assert property (
		seg_run <= BLINK_HALF_CYCLES) else $error("segment lit too long");
endmodule

bind charge_gauge_status_registers charge_gauge_sva #(
	.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) i_sva (
	.CLK_I                   (CLK_I),
	.RST_N_I                 (RST_N_I),
	.CMD_VALID_I             (CMD_VALID_I),
	.CMD_BYTE_I              (CMD_BYTE_I),
	.CMD_DATA_I              (CMD_DATA_I),
	.RSP_VALID_O             (RSP_VALID_O),
	.RSP_DATA_O              (RSP_DATA_O),
	.CHARGE_COUNT_I          (CHARGE_COUNT_I),
	.DISCHARGE_COUNT_I       (DISCHARGE_COUNT_I),
	.SELF_DISCHARGE_COUNT_I  (SELF_DISCHARGE_COUNT_I),
	.SENSE_CHARGE_I          (SENSE_CHARGE_I),
	.CELL_OVERVOLT_I         (CELL_OVERVOLT_I),
	.TEMPERATURE_CODE_I      (TEMPERATURE_CODE_I),
	.FIRST_DISPLAY_SEGMENT_O (FIRST_DISPLAY_SEGMENT_O),
	.GAUGE_LEVEL_O           (GAUGE_LEVEL_O)
);

`default_nettype wire

// ===== tb/charge_gauge_status_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module charge_gauge_status_registers_tb_top;
	localparam int unsigned HALF = 4;
	logic              CLK_I = 1'b0;
	logic              RST_N_I = 1'b0;
	logic              cvalid, rvalid, seg;
	logic              chg = 1'b0, dis = 1'b0, sds = 1'b0, sense = 1'b0, present = 1'b0;
	logic              corrupt = 1'b0, ovolt = 1'b0, empty = 1'b0, discharge_overload_flag = 1'b0, strap = 1'b0;
	logic [3:0]        tcode = 4'h5, gauge;
	logic signed [7:0] deg = 8'sh19;
	logic [7:0]        cbyte, cdata, rdata, programmed_full_capacity = 8'h40, seed = 8'h27;
	logic signed [7:0] tv[5] = '{8'sh19, -8'sh0A, 8'sh02, 8'sh05, -8'sh19};
	logic [7:0]        ge[5] = '{8'h08, 8'h06, 8'h06, 8'h08, 8'h04};
	int                n_errors = 0, comparisons = 0, cyc = 0, q = 0;

	always #4 CLK_I = ~CLK_I;

	gauge_host_model i_host (.clk_i(CLK_I), .rsp_valid_i(rvalid), .rsp_data_i(rdata),
		.cmd_valid_o(cvalid), .cmd_byte_o(cbyte), .cmd_data_o(cdata));

	charge_gauge_status_registers #(.BLINK_HALF_CYCLES(HALF)) i_dut (
		.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CMD_VALID_I(cvalid), .CMD_BYTE_I(cbyte),
		.CMD_DATA_I(cdata), .RSP_VALID_O(rvalid), .RSP_DATA_O(rdata), .CHARGE_COUNT_I(chg),
		.DISCHARGE_COUNT_I(dis), .SELF_DISCHARGE_COUNT_I(sds), .SENSE_CHARGE_I(sense),
		.CELL_PRESENT_I(present), .REG_CORRUPT_I(corrupt), .CELL_OVERVOLT_I(ovolt),
		.CELL_EMPTY_I(empty), .DISCHARGE_OVERLOAD_I(discharge_overload_flag), .TEMPERATURE_CODE_I(tcode),
		.TEMPERATURE_DEG_I(deg), .PROGRAMMED_FULL_CAPACITY_I(programmed_full_capacity),
		.FOURTH_PROGRAM_INPUT_I(strap), .FIRST_DISPLAY_SEGMENT_O(seg), .GAUGE_LEVEL_O(gauge));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Quarter-count weight of one event of kind k at code c
	function automatic int wt(input int k, input logic [3:0] c);
		if (k == 1) return 4;
		if (k == 0) return c >= 4'h4 ? 4 : (c >= 4'h2 ? 3 : 2);
		return c >= 4'h8 ? 8 : (c >= 4'h4 ? 4 : 2);
	endfunction
	task automatic end_of_test();
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		i_host.rd(a, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d & m, e);
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge CLK_I);
	endtask
	task automatic ev(input int k, input int n);
		q += (k == 0 ? n : -n) * wt(k, tcode);
		repeat (n) begin
			@(negedge CLK_I);
			{chg, dis, sds} = 3'b100 >> k;
			@(negedge CLK_I);
			{chg, dis, sds} = 3'b000;
		end
	endtask
	task automatic rst(input logic s);
		@(negedge CLK_I);
		RST_N_I = 1'b0;
		strap = s;
		w(8);
		RST_N_I = 1'b1;
		w(2);
	endtask

	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	initial begin
		int n;
		rst(1'b0);
		rdc(7'h01, 8'hEA, 8'h40);
		rdc(7'h03, 8'hFF, 8'h40);
		rdc(7'h17, 8'hFF, 8'h00);
		rdc(7'h05, 8'hFF, 8'h40);
		i_host.wr(7'h03, 8'h20);
		rdc(7'h03, 8'hFF, 8'h20);
		foreach (tv[i]) begin
			@(negedge CLK_I);
			deg = tv[i];
			w(4);
			rdc(7'h02, 8'h0F, ge[i]);
			chk({4'h0, gauge}, ge[i]);
		end
		for (int c = 0; c < 13; c++) begin
			@(negedge CLK_I);
			tcode = c[3:0];
			w(2);
			rdc(7'h02, 8'hF0, {c[3:0], 4'h0});
		end
		seed = lfsr(seed);
		i_host.wr(7'h04, seed);
		rdc(7'h04, 8'hFF, seed);
		i_host.wr(7'h17, seed);
		rdc(7'h17, 8'hFF, 8'h00);
		rdc(7'h10, 8'hFF, 8'h00);
		i_host.wr(7'h03, 8'h10);
		seed = lfsr(seed);
		n = seed[2:0] + 1;
		tcode = 4'h5;
		ev(0, n);
		tcode = 4'h2;
		ev(0, 4);
		rdc(7'h17, 8'hFF, 8'(q / 4));
		ev(1, n);
		tcode = 4'h8;
		ev(2, 1);
		rdc(7'h17, 8'hFF, 8'(q / 4));
		sense = 1'b1;
		w(3);
		rdc(7'h01, 8'h80, 8'h80);
		rdc(7'h17, 8'hFF, 8'h00);
		sense = 1'b0;
		w(2);
		rdc(7'h01, 8'h80, 8'h00);
		discharge_overload_flag = 1'b1;
		empty = 1'b1;
		w(3);
		rdc(7'h01, 8'h02, 8'h00);
		discharge_overload_flag = 1'b0;
		w(3);
		empty = 1'b0;
		n = 0;
		repeat (40) begin
			@(negedge CLK_I);
			n += seg;
		end
		chk(n[7:0], 8'h14);
		rdc(7'h01, 8'h42, 8'h02);
		sense = 1'b1;
		w(3);
		rdc(7'h01, 8'h02, 8'h00);
		chk({7'h00, seg}, 8'h00);
		sense = 1'b0;
		ovolt = 1'b1;
		w(2);
		rdc(7'h01, 8'h20, 8'h20);
		ovolt = 1'b0;
		present = 1'b1;
		corrupt = 1'b1;
		w(2);
		rdc(7'h01, 8'h60, 8'h40);
		present = 1'b0;
		corrupt = 1'b0;
		seed = lfsr(seed);
		i_host.wr(7'h05, seed);
		rdc(7'h05, 8'hFF, seed);
		i_host.soft_reset();
		w(2);
		rdc(7'h05, 8'hFF, 8'h40);
		rdc(7'h01, 8'h48, 8'h40);
		rdc(7'h03, 8'hFF, 8'h40);
		sense = 1'b1;
		w(3);
		rdc(7'h01, 8'hC0, 8'h80);
		sense = 1'b0;
		ev(1, 1);
		rdc(7'h01, 8'h08, 8'h08);
		ev(1, 256);
		empty = 1'b1;
		w(2);
		empty = 1'b0;
		rdc(7'h05, 8'hFF, 8'h01);
		rdc(7'h01, 8'h0A, 8'h02);
		programmed_full_capacity = seed;
		rst(1'b1);
		rdc(7'h05, 8'hFF, programmed_full_capacity);
		rdc(7'h03, 8'hFF, 8'h00);
		ev(1, 3);
		rdc(7'h17, 8'hFF, 8'h00);
		end_of_test();
	end
endmodule

`default_nettype wire
